// ### hw/cspsl_pkg.sv
// constants, types and register map of the clock select, prescale and sleep block
// What this block does
// - source code 00 internal 8 MHz, 01 128 kHz watchdog osc, 10 external, 11 reserved.
// - source changes at run time without any glitch on the main clock.
// - source write counts only within four instruction cycles after the unlock signature.
// - divide write counts only within four instruction cycles after the unlock signature.
// - system clock is main clock over two to the divide code, codes 0 to 8.
// - divide code resets to 0011, divide by 8.
// - upper four bits of the divide register read as zero.
// - divided system clock drives core and all synchronous peripherals together.
// - factory trim loads into the trim register at the first edge after reset release; software may overwrite.
// - trim value tunes oscillator monotonically, 00 lowest, FF highest.
// - sleep only on sleep instruction with arm bit set; mode field picks mode.
// - after wake core halts four cycles plus start-up, then runs handler.
// - state survives sleep; reset during sleep wakes to the reset vector.
// - idle stops core and memory clocks only; any enabled interrupt wakes.
// - noise reduction stops io, core, memory clocks; limited wake sources.
// - power-down stops oscillator and all clocks; few asynchronous wake sources.
// - standby is power-down with main oscillator kept running.
// - in deep modes irq zero wakes by level only, two-wire by address match only.
// - converter enabled at idle or noise-reduction entry starts a conversion.
// - divide change never shows a faster intermediate clock; applies at period end.
// - power-down wake waits 6 main clock cycles; other modes add no delay.
// - sleep codes 011, 101, 110, 111 are reserved and enter no sleep.
package cspsl_pkg;
   localparam int AXI_ADDR_W = 12;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_CLK_DIV = 8'h36;
   localparam logic [7:0] IDX_CLK_SRC = 8'h37;
   localparam logic [7:0] IDX_OSC_TRIM = 8'h39;
   localparam logic [7:0] IDX_CORE_CTRL = 8'h3A;
   localparam logic [7:0] IDX_CHANGE_PROTECT = 8'h3C;
   localparam logic [7:0] IDX_STATUS = 8'h3D;
   // field positions
   localparam int SRC_LSB = 0;
   localparam int DIV_LSB = 0;
   localparam int ARM_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int STAT_SRC_LSB = 0;
   localparam int STAT_DIV_LSB = 2;
   localparam int STAT_SLEEP_BIT = 6;
   localparam int STAT_WINDOW_BIT = 7;
   // reset values
   localparam logic [1:0] RST_CLK_SRC = 2'h0;
   localparam logic [3:0] RST_CLK_DIV = 4'h3;
   localparam logic [7:0] RST_OSC_TRIM = 8'h00;
   localparam logic [2:0] RST_MODE = 3'h0;
   // codes
   localparam logic [1:0] SRC_OSC8 = 2'h0;
   localparam logic [1:0] SRC_OSC128 = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h2;
   localparam logic [1:0] SRC_RESERVED = 2'h3;
   localparam logic [3:0] DIV_MAX = 4'h8;
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_NOISE = 3'h1;
   localparam logic [2:0] MODE_PDOWN = 3'h2;
   localparam logic [2:0] MODE_STANDBY = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing counts
   localparam logic [2:0] PROTECT_WINDOW_CYCLES = 3'h4;
   localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;
   localparam logic [2:0] OSC_START_CYCLES = 3'h6;

   typedef enum logic [1:0] {
      FSM_RUN,
      FSM_SLEEP,
      FSM_OSC_START,
      FSM_WAKE_HALT
   } cspsl_fsm_t;

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_idx;
      logic aw_bad;
      logic w_held;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [1:0] src_sel;
      logic [1:0] src_active;
      logic src_switching;
      logic main_tick;
      logic [3:0] div_sel;
      logic [3:0] div_active;
      logic [7:0] div_cnt;
      logic sys_tick;
      logic [7:0] trim;
      logic trim_loaded;
      logic arm;
      logic [2:0] mode;
      logic [2:0] sleep_mode;
      logic [2:0] protect_cnt;
      cspsl_fsm_t fsm;
      logic [2:0] wait_cnt;
      logic adc_start;
      logic wake;
   } cspsl_state_t;
endpackage

// ### hw/cspsl_top.sv
// clock source select, system clock prescaler and sleep control with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cspsl_top #(
   parameter logic [7:0] UNLOCK_SIGNATURE = 8'hA5
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // AXI4-Lite register slave
   input wire logic [cspsl_pkg::AXI_ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [cspsl_pkg::AXI_ADDR_W-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // source clock edges, one-cycle pulses
   input wire logic i_osc8_tick,
   input wire logic i_osc128_tick,
   input wire logic i_ext_tick,
   // factory trim byte from nonvolatile storage
   input wire logic [7:0] i_factory_trim,
   // core and converter side
   input wire logic i_sleep_exec,
   input wire logic i_adc_enabled,
   // wake sources, levels
   input wire logic i_wake_ext0_level,
   input wire logic i_wake_ext0_edge,
   input wire logic i_wake_pin_change,
   input wire logic i_wake_watchdog,
   input wire logic i_wake_twi_addr,
   input wire logic i_wake_twi_other,
   input wire logic i_wake_adc,
   input wire logic i_wake_other_io,
   // clocks and clock gates
   output logic o_main_tick,
   output logic o_sys_tick,
   output logic [7:0] o_osc_trim,
   output logic o_core_clk_en,
   output logic o_nvm_clk_en,
   output logic o_io_clk_en,
   output logic o_adc_clk_en,
   output logic o_main_src_en,
   output logic o_core_halt,
   output logic o_adc_start,
   output logic o_wake
);

   ////////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic src_tick(input logic [1:0] sel, input logic t8, input logic t128,
                                     input logic text);
      logic r;
      r = 1'b0;
      unique case (sel)
         cspsl_pkg::SRC_OSC8: r = t8;
         cspsl_pkg::SRC_OSC128: r = t128;
         cspsl_pkg::SRC_EXT: r = text;
         cspsl_pkg::SRC_RESERVED: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] div_mask(input logic [3:0] code);
      logic [8:0] m;
      m = (9'h001 << code) - 9'h001;
      return m[7:0];
   endfunction

   function automatic logic mode_valid(input logic [2:0] m);
      return (m == cspsl_pkg::MODE_IDLE) || (m == cspsl_pkg::MODE_NOISE) ||
             (m == cspsl_pkg::MODE_PDOWN) || (m == cspsl_pkg::MODE_STANDBY);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   cspsl_pkg::cspsl_state_t s_q;
   cspsl_pkg::cspsl_state_t s_d;
   logic old_tick;
   logic new_tick;
   logic src_en;
   logic main_tick;
   logic wake_hit;
   logic do_write;
   logic window_open;
   logic [cspsl_pkg::AXI_ADDR_W-1:0] ar_addr;
   logic [7:0] ar_idx;
   logic ar_bad;
   logic [7:0] rd_val;
   logic [7:0] status;
   logic deep;

   assign ar_addr = i_s_axi_araddr;
   assign ar_idx = ar_addr[9:2];
   assign ar_bad = |ar_addr[cspsl_pkg::AXI_ADDR_W-1:10];
   assign window_open = s_q.protect_cnt != 3'h0;
   assign deep = s_q.sleep_mode != cspsl_pkg::MODE_IDLE;

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      s_d.adc_start = 1'b0;
      s_d.wake = 1'b0;
      s_d.sys_tick = 1'b0;
      old_tick = src_tick(s_q.src_active, i_osc8_tick, i_osc128_tick, i_ext_tick);
      new_tick = src_tick(s_q.src_sel, i_osc8_tick, i_osc128_tick, i_ext_tick);
      // oscillator off only in power-down sleep
      src_en = !((s_q.fsm == cspsl_pkg::FSM_SLEEP) &&
                 (s_q.sleep_mode == cspsl_pkg::MODE_PDOWN));

      // finish the old period, then hold low until the new source's edge
      main_tick = 1'b0;
      if (s_q.src_sel == s_q.src_active) begin
         main_tick = old_tick && src_en;
         s_d.src_switching = 1'b0;
      end else if (!s_q.src_switching) begin
         main_tick = old_tick && src_en;
         if (old_tick && src_en) begin
            s_d.src_switching = 1'b1;
         end
      end else if (new_tick && src_en) begin
         main_tick = 1'b1;
         s_d.src_active = s_q.src_sel;
         s_d.src_switching = 1'b0;
      end
      s_d.main_tick = main_tick;

      // ripple prescaler; new factor only at a period boundary
      if (main_tick) begin
         if ((s_q.div_cnt & div_mask(s_q.div_active)) == div_mask(s_q.div_active)) begin
            s_d.div_cnt = 8'h00;
            s_d.sys_tick = 1'b1;
            s_d.div_active = s_q.div_sel;
         end else begin
            s_d.div_cnt = s_q.div_cnt + 8'h01;
         end
      end

      // protection window, counted in system cycles
      if (s_q.sys_tick && window_open) begin
         s_d.protect_cnt = s_q.protect_cnt - 3'h1;
      end

      // factory trim loaded at the first edge after reset release
      if (!s_q.trim_loaded) begin
         s_d.trim = i_factory_trim;
         s_d.trim_loaded = 1'b1;
      end

      // AXI write channels, taken in either order
      if (i_s_axi_awvalid && !s_q.aw_held) begin
         s_d.aw_held = 1'b1;
         s_d.aw_idx = i_s_axi_awaddr[9:2];
         s_d.aw_bad = |i_s_axi_awaddr[cspsl_pkg::AXI_ADDR_W-1:10];
      end
      if (i_s_axi_wvalid && !s_q.w_held) begin
         s_d.w_held = 1'b1;
         s_d.w_data = i_s_axi_wdata[7:0];
         s_d.w_strb0 = i_s_axi_wstrb[0];
      end
      if (s_q.bvalid && i_s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
      if (do_write) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = cspsl_pkg::RESP_OKAY;
         if (s_q.aw_bad) begin
            s_d.bresp = cspsl_pkg::RESP_SLVERR;
         end else begin
            unique case (s_q.aw_idx)
               cspsl_pkg::IDX_CLK_SRC: begin
                  if (s_q.w_strb0 && window_open) begin
                     s_d.protect_cnt = 3'h0;
                     if (s_q.w_data[cspsl_pkg::SRC_LSB +: 2] != cspsl_pkg::SRC_RESERVED) begin
                        s_d.src_sel = s_q.w_data[cspsl_pkg::SRC_LSB +: 2];
                     end
                  end
               end
               cspsl_pkg::IDX_CLK_DIV: begin
                  if (s_q.w_strb0 && window_open) begin
                     s_d.protect_cnt = 3'h0;
                     if (s_q.w_data[cspsl_pkg::DIV_LSB +: 4] <= cspsl_pkg::DIV_MAX) begin
                        s_d.div_sel = s_q.w_data[cspsl_pkg::DIV_LSB +: 4];
                     end
                  end
               end
               cspsl_pkg::IDX_OSC_TRIM: begin
                  if (s_q.w_strb0 && s_q.trim_loaded) begin
                     s_d.trim = s_q.w_data;
                  end
               end
               cspsl_pkg::IDX_CORE_CTRL: begin
                  if (s_q.w_strb0) begin
                     s_d.arm = s_q.w_data[cspsl_pkg::ARM_BIT];
                     s_d.mode = s_q.w_data[cspsl_pkg::MODE_LSB +: 3];
                  end
               end
               cspsl_pkg::IDX_CHANGE_PROTECT: begin
                  if (s_q.w_strb0 && (s_q.w_data == UNLOCK_SIGNATURE)) begin
                     s_d.protect_cnt = cspsl_pkg::PROTECT_WINDOW_CYCLES;
                  end
               end
               cspsl_pkg::IDX_STATUS: begin
               end
               default: begin
                  s_d.bresp = cspsl_pkg::RESP_SLVERR;
               end
            endcase
         end
      end

      // AXI read channel
      status = 8'h00;
      status[cspsl_pkg::STAT_SRC_LSB +: 2] = s_q.src_active;
      status[cspsl_pkg::STAT_DIV_LSB +: 4] = s_q.div_active;
      status[cspsl_pkg::STAT_SLEEP_BIT] = s_q.fsm != cspsl_pkg::FSM_RUN;
      status[cspsl_pkg::STAT_WINDOW_BIT] = window_open;
      rd_val = 8'h00;
      unique case (ar_idx)
         cspsl_pkg::IDX_CLK_SRC: rd_val = {6'h00, s_q.src_sel};
         cspsl_pkg::IDX_CLK_DIV: rd_val = {4'h0, s_q.div_sel};
         cspsl_pkg::IDX_OSC_TRIM: rd_val = s_q.trim;
         cspsl_pkg::IDX_CORE_CTRL: rd_val = {4'h0, s_q.mode, s_q.arm};
         cspsl_pkg::IDX_CHANGE_PROTECT: rd_val = 8'h00;
         cspsl_pkg::IDX_STATUS: rd_val = status;
         default: rd_val = 8'h00;
      endcase
      if (s_q.rvalid && i_s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (i_s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd_val;
         s_d.rresp = cspsl_pkg::RESP_OKAY;
         if (ar_bad || !((ar_idx == cspsl_pkg::IDX_CLK_SRC) ||
                         (ar_idx == cspsl_pkg::IDX_CLK_DIV) ||
                         (ar_idx == cspsl_pkg::IDX_OSC_TRIM) ||
                         (ar_idx == cspsl_pkg::IDX_CORE_CTRL) ||
                         (ar_idx == cspsl_pkg::IDX_CHANGE_PROTECT) ||
                         (ar_idx == cspsl_pkg::IDX_STATUS))) begin
            s_d.rdata = 8'h00;
            s_d.rresp = cspsl_pkg::RESP_SLVERR;
         end
      end

      // wake qualification by the mode entered
      if (s_q.sleep_mode == cspsl_pkg::MODE_IDLE) begin
         wake_hit = i_wake_ext0_level || i_wake_ext0_edge || i_wake_pin_change ||
                    i_wake_watchdog || i_wake_twi_addr || i_wake_twi_other ||
                    i_wake_adc || i_wake_other_io;
      end else if (s_q.sleep_mode == cspsl_pkg::MODE_NOISE) begin
         wake_hit = i_wake_ext0_level || i_wake_pin_change || i_wake_watchdog ||
                    i_wake_twi_addr || i_wake_adc;
      end else begin
         wake_hit = i_wake_ext0_level || i_wake_pin_change || i_wake_watchdog ||
                    i_wake_twi_addr;
      end

      // sleep sequencer; registers and memory are untouched by it
      unique case (s_q.fsm)
         cspsl_pkg::FSM_RUN: begin
            if (i_sleep_exec && s_q.arm && mode_valid(s_q.mode)) begin
               s_d.fsm = cspsl_pkg::FSM_SLEEP;
               s_d.sleep_mode = s_q.mode;
               s_d.adc_start = i_adc_enabled && ((s_q.mode == cspsl_pkg::MODE_IDLE) ||
                                                 (s_q.mode == cspsl_pkg::MODE_NOISE));
            end
         end
         cspsl_pkg::FSM_SLEEP: begin
            if (wake_hit) begin
               s_d.wait_cnt = 3'h0;
               if (s_q.sleep_mode == cspsl_pkg::MODE_PDOWN) begin
                  s_d.fsm = cspsl_pkg::FSM_OSC_START;
               end else begin
                  s_d.fsm = cspsl_pkg::FSM_WAKE_HALT;
               end
            end
         end
         cspsl_pkg::FSM_OSC_START: begin
            if (main_tick) begin
               if (s_q.wait_cnt == cspsl_pkg::OSC_START_CYCLES - 3'h1) begin
                  s_d.wait_cnt = 3'h0;
                  s_d.fsm = cspsl_pkg::FSM_WAKE_HALT;
               end else begin
                  s_d.wait_cnt = s_q.wait_cnt + 3'h1;
               end
            end
         end
         cspsl_pkg::FSM_WAKE_HALT: begin
            if (s_q.sys_tick) begin
               if (s_q.wait_cnt == cspsl_pkg::WAKE_HALT_CYCLES - 3'h1) begin
                  s_d.wait_cnt = 3'h0;
                  s_d.fsm = cspsl_pkg::FSM_RUN;
                  s_d.wake = 1'b1;
               end else begin
                  s_d.wait_cnt = s_q.wait_cnt + 3'h1;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q <= '0;
         s_q.src_sel <= cspsl_pkg::RST_CLK_SRC;
         s_q.src_active <= cspsl_pkg::RST_CLK_SRC;
         s_q.div_sel <= cspsl_pkg::RST_CLK_DIV;
         s_q.div_active <= cspsl_pkg::RST_CLK_DIV;
         s_q.trim <= cspsl_pkg::RST_OSC_TRIM;
         s_q.mode <= cspsl_pkg::RST_MODE;
         s_q.sleep_mode <= cspsl_pkg::RST_MODE;
         s_q.fsm <= cspsl_pkg::FSM_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_s_axi_awready = !s_q.aw_held;
   assign o_s_axi_wready = !s_q.w_held;
   assign o_s_axi_bvalid = s_q.bvalid;
   assign o_s_axi_bresp = s_q.bresp;
   assign o_s_axi_arready = !s_q.rvalid;
   assign o_s_axi_rvalid = s_q.rvalid;
   assign o_s_axi_rdata = {24'h000000, s_q.rdata};
   assign o_s_axi_rresp = s_q.rresp;
   assign o_main_tick = s_q.main_tick;
   assign o_sys_tick = s_q.sys_tick;
   assign o_osc_trim = s_q.trim;
   assign o_core_clk_en = s_q.fsm == cspsl_pkg::FSM_RUN;
   assign o_nvm_clk_en = (s_q.fsm == cspsl_pkg::FSM_RUN) ||
                         (s_q.fsm == cspsl_pkg::FSM_WAKE_HALT);
   assign o_io_clk_en = (s_q.fsm == cspsl_pkg::FSM_RUN) ||
                        (s_q.fsm == cspsl_pkg::FSM_WAKE_HALT) ||
                        ((s_q.fsm == cspsl_pkg::FSM_SLEEP) && !deep);
   assign o_adc_clk_en = (s_q.fsm == cspsl_pkg::FSM_RUN) ||
                         (s_q.fsm == cspsl_pkg::FSM_WAKE_HALT) ||
                         ((s_q.fsm == cspsl_pkg::FSM_SLEEP) &&
                          ((s_q.sleep_mode == cspsl_pkg::MODE_IDLE) ||
                           (s_q.sleep_mode == cspsl_pkg::MODE_NOISE)));
   assign o_main_src_en = !((s_q.fsm == cspsl_pkg::FSM_SLEEP) &&
                            (s_q.sleep_mode == cspsl_pkg::MODE_PDOWN));
   assign o_core_halt = s_q.fsm != cspsl_pkg::FSM_RUN;
   assign o_adc_start = s_q.adc_start;
   assign o_wake = s_q.wake;

endmodule // cspsl_top

// ### verification/cspsl_sva.sv
// port assertions for the clock select, prescale and sleep block
`timescale 1ns/1ps
module cspsl_sva (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // register bus
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [1:0] o_s_axi_bresp,
   // clocks and gates
   input wire logic i_osc8_tick,
   input wire logic i_osc128_tick,
   input wire logic i_ext_tick,
   input wire logic o_main_tick,
   input wire logic o_core_clk_en,
   input wire logic o_io_clk_en,
   input wire logic o_adc_clk_en,
   input wire logic o_main_src_en,
   input wire logic o_core_halt,
   input wire logic o_adc_start,
   input wire logic o_wake
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   //////////////////////////////
   sequence ar_take;
      i_s_axi_arvalid && o_s_axi_arready;
   endsequence
   sequence halt_release;
      o_core_halt ##1 !o_core_halt;
   endsequence
   //////////////////////////////
   rd_answer_a: assert property (ar_take |=> o_s_axi_rvalid)
      else $error("read request not answered");
   rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
      o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read answer dropped");
   wr_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
      o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write answer dropped");
   rd_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   tick_gate_a: assert property (!(i_osc8_tick || i_osc128_tick || i_ext_tick) |=>
      !o_main_tick)
      else $error("main tick without source tick");
   core_run_a: assert property (o_core_clk_en |->
      o_io_clk_en && o_adc_clk_en && o_main_src_en)
      else $error("clock stopped while core runs");
   src_off_a: assert property (!o_main_src_en |-> !o_io_clk_en && !o_adc_clk_en)
      else $error("clock enabled with source off");
   adc_start_a: assert property (o_adc_start |-> o_adc_clk_en && o_core_halt)
      else $error("conversion start outside sleep entry");
   wake_run_a: assert property (halt_release |-> ##[0:1] o_wake)
      else $error("resume without wake pulse");
endmodule // cspsl_sva

bind cspsl_top cspsl_sva cspsl_sva_inst (.*);

// ### verification/cspsl_tb.sv
// self-checking bench for the clock select, prescale and sleep block
`timescale 1ns/1ps
module cspsl_tb;
   // unlock value, arbitrary
   localparam logic [7:0] SIG = 8'h3C;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [cspsl_pkg::AXI_ADDR_W-1:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
   logic [31:0] i_s_axi_wdata = 32'h0;
   logic [3:0] i_s_axi_wstrb = 4'hF;
   logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
   logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
   logic i_osc8_tick = 1'b0, i_osc128_tick = 1'b0, i_ext_tick = 1'b0;
   logic [7:0] i_factory_trim = 8'h5C;
   logic i_sleep_exec = 1'b0;
   logic i_adc_enabled = 1'b1;
   logic [7:0] wk = 8'h00;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, wresp;
   logic [31:0] o_s_axi_rdata;
   logic o_main_tick, o_sys_tick, o_core_clk_en, o_nvm_clk_en, o_io_clk_en, o_adc_clk_en;
   logic o_main_src_en, o_core_halt, o_adc_start, o_wake;
   logic [7:0] o_osc_trim;
   int n_errors = 0;
   int total_checks = 0;
   int tc = 0;
   int n_adc = 0;
   //////////////////////////////
   cspsl_top #(.UNLOCK_SIGNATURE(SIG)) cspsl_top_inst (
      .*,
      .i_wake_ext0_level(wk[0]),
      .i_wake_ext0_edge(wk[1]),
      .i_wake_pin_change(wk[2]),
      .i_wake_watchdog(wk[3]),
      .i_wake_twi_addr(wk[4]),
      .i_wake_twi_other(wk[5]),
      .i_wake_adc(wk[6]),
      .i_wake_other_io(wk[7])
   );
   initial begin
      forever #4 i_clk = ~i_clk;
   end
   // source ticks at three unlike rates
   always @(posedge i_clk) begin
      tc <= tc + 1;
      i_osc8_tick <= (tc % 2 == 0);
      i_osc128_tick <= (tc % 5 == 0);
      i_ext_tick <= (tc % 3 == 0);
      n_adc <= n_adc + int'(o_adc_start);
   end
   //////////////////////////////
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] e);
      total_checks++;
      if (got !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, got);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      bit a, w, b;
      a = 1;
      w = 1;
      b = 1;
      n = 0;
      @(posedge i_clk);
      i_s_axi_awaddr <= {2'b00, idx, 2'b00};
      i_s_axi_wdata <= {24'h000000, d};
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      while ((a || w || b) && n < 200) begin
         @(posedge i_clk);
         n++;
         if (a && o_s_axi_awready) begin
            a = 0;
            i_s_axi_awvalid <= 1'b0;
         end
         if (w && o_s_axi_wready) begin
            w = 0;
            i_s_axi_wvalid <= 1'b0;
         end
         if (b && o_s_axi_bvalid) begin
            b = 0;
            i_s_axi_bready <= 1'b0;
            wresp = o_s_axi_bresp;
         end
      end
      if (a || w || b) n_errors++;
   endtask
   task automatic rdchk(input string s, input logic [7:0] idx, input logic [31:0] e,
                        input logic [1:0] er);
      int n;
      bit a;
      a = 1;
      n = 0;
      @(posedge i_clk);
      i_s_axi_araddr <= {2'b00, idx, 2'b00};
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
         if (a && o_s_axi_arready) begin
            a = 0;
            i_s_axi_arvalid <= 1'b0;
         end
      end while (!o_s_axi_rvalid && n < 200);
      i_s_axi_rready <= 1'b0;
      chk(s, o_s_axi_rdata, e);
      chk(s, o_s_axi_rresp, er);
   endtask
   task automatic pwr(input logic [7:0] idx, input logic [7:0] d);
      wr(cspsl_pkg::IDX_CHANGE_PROTECT, SIG);
      wr(idx, d);
   endtask
   task automatic t_period(input int e);
      int n;
      int k;
      n = 0;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (!o_sys_tick && k < 3000);
      do begin
         @(posedge i_clk);
         k++;
         n += int'(o_main_tick);
      end while (!o_sys_tick && k < 6000);
      chk("period", n, e);
   endtask
   //////////////////////////////
   task automatic t_reset();
      rdchk("div", cspsl_pkg::IDX_CLK_DIV, 32'h03, cspsl_pkg::RESP_OKAY);
      rdchk("src", cspsl_pkg::IDX_CLK_SRC, 32'h00, cspsl_pkg::RESP_OKAY);
      rdchk("trim", cspsl_pkg::IDX_OSC_TRIM, 32'h5C, cspsl_pkg::RESP_OKAY);
      rdchk("unmapped", 8'h10, 32'h00, cspsl_pkg::RESP_SLVERR);
      wr(8'h10, 8'h01);
      chk("unmapped_wr", wresp, cspsl_pkg::RESP_SLVERR);
      wr(cspsl_pkg::IDX_OSC_TRIM, 8'hFF);
      chk("trim_out", o_osc_trim, 8'hFF);
   endtask
   task automatic t_protect();
      wr(cspsl_pkg::IDX_CLK_DIV, 8'h00);
      rdchk("div_locked", cspsl_pkg::IDX_CLK_DIV, 32'h03, cspsl_pkg::RESP_OKAY);
      pwr(cspsl_pkg::IDX_CLK_DIV, 8'h01);
      rdchk("div_open", cspsl_pkg::IDX_CLK_DIV, 32'h01, cspsl_pkg::RESP_OKAY);
      wr(cspsl_pkg::IDX_CLK_DIV, 8'h00);
      rdchk("div_once", cspsl_pkg::IDX_CLK_DIV, 32'h01, cspsl_pkg::RESP_OKAY);
      wr(cspsl_pkg::IDX_CHANGE_PROTECT, SIG);
      repeat (60) @(posedge i_clk);
      wr(cspsl_pkg::IDX_CLK_DIV, 8'h00);
      rdchk("div_late", cspsl_pkg::IDX_CLK_DIV, 32'h01, cspsl_pkg::RESP_OKAY);
      pwr(cspsl_pkg::IDX_CLK_DIV, 8'h09);
      rdchk("div_rsvd", cspsl_pkg::IDX_CLK_DIV, 32'h01, cspsl_pkg::RESP_OKAY);
      pwr(cspsl_pkg::IDX_CLK_DIV, 8'hF2);
      rdchk("div_upper", cspsl_pkg::IDX_CLK_DIV, 32'h02, cspsl_pkg::RESP_OKAY);
      t_period(4);
      pwr(cspsl_pkg::IDX_CLK_DIV, 8'h08);
      t_period(256);
      pwr(cspsl_pkg::IDX_CLK_DIV, 8'h00);
      t_period(1);
   endtask
   task automatic t_source();
      pwr(cspsl_pkg::IDX_CLK_SRC, 8'h03);
      rdchk("src_rsvd", cspsl_pkg::IDX_CLK_SRC, 32'h00, cspsl_pkg::RESP_OKAY);
      pwr(cspsl_pkg::IDX_CLK_SRC, 8'h02);
      rdchk("src_ext", cspsl_pkg::IDX_CLK_SRC, 32'h02, cspsl_pkg::RESP_OKAY);
      repeat (20) @(posedge i_clk);
      rdchk("status", cspsl_pkg::IDX_STATUS, 32'h02, cspsl_pkg::RESP_OKAY);
   endtask
   task automatic t_sleep(input logic [7:0] c, input int bad, input int good,
                          input logic [4:0] en);
      int n;
      int a0;
      wr(cspsl_pkg::IDX_CORE_CTRL, c);
      a0 = n_adc;
      @(posedge i_clk);
      i_sleep_exec <= 1'b1;
      @(posedge i_clk);
      i_sleep_exec <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk("gates", {o_core_clk_en, o_nvm_clk_en, o_io_clk_en, o_adc_clk_en,
                    o_main_src_en}, en);
      chk("adc_start", n_adc - a0, (c[0] && c[3:1] < 3'h2) ? 1 : 0);
      if (en[4]) return;
      if (bad >= 0) begin
         wk[bad] <= 1'b1;
         repeat (20) @(posedge i_clk);
         chk("no_wake", o_core_halt, 1'b1);
      end
      wk[good] <= 1'b1;
      n = 0;
      while (!o_wake && n < 500) begin
         @(posedge i_clk);
         n++;
      end
      wk <= 8'h00;
      chk("wake", o_wake, 1'b1);
      chk("halt_len", 32'(n >= 9), 1);
      chk("run", o_core_halt, 1'b0);
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   //////////////////////////////
   initial begin
      repeat (30000) @(posedge i_clk);
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      t_reset();
      t_protect();
      t_source();
      t_sleep(8'h00, -1, 7, 5'h1F);
      t_sleep(8'h07, -1, 7, 5'h1F);
      t_sleep(8'h01, -1, 7, 5'h07);
      t_sleep(8'h03, 7, 6, 5'h03);
      t_sleep(8'h09, 1, 0, 5'h01);
      t_sleep(8'h05, 5, 3, 5'h00);
      wrap_up();
   end
endmodule // cspsl_tb
